// ### pkg/sdts_map.vh
// constants for the sigma-delta decimation and timestamp channel
// assumes a 32-bit apb slave on pclk and a modulator bitstream on pins
`ifndef SDTS_MAP_VH
`define SDTS_MAP_VH
`define SDTS_OFF_CFG      8'h00
`define SDTS_OFF_TSTAMP   8'h04
`define SDTS_OFF_RESULT   8'h08
`define SDTS_OFF_STATUS   8'h0C
`define SDTS_OFF_ELAPSED  8'h10
`define SDTS_GRADE_OFF    2'h0
`define SDTS_GRADE_CIC2   2'h1
`define SDTS_GRADE_CIC3   2'h2
`define SDTS_GRADE_FAST   2'h3
`define SDTS_CFG_GRADE    1:0
`define SDTS_CFG_EN       2
`define SDTS_CFG_FACTOR   15:8
`define SDTS_CFG_OUTLEN   23:16
`define SDTS_CFG_RESET    32'h0000_0000
`define SDTS_STAT_RDY     0
`define SDTS_STAT_OVR     1
`define SDTS_CNT_W        8
`define SDTS_RES_W        24
`define SDTS_ELA_W        17
`define SDTS_ZERO8        8'h00
`define SDTS_ONE8         8'h01
`define SDTS_ZERO24       24'h00_0000
`define SDTS_ONE17        17'h0_0001
`define SDTS_PLUS1        24'h00_0001
`define SDTS_MINUS1       24'hFF_FFFF
`endif

// ### rtl/sdts_cic.v
// cic integrate and dump core for one filter channel
// assumes one-cycle tick and dump strobes from the channel control on pclk
`timescale 1ns/1ps
`default_nettype none
`include "sdts_map.vh"
module sdts_cic (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   tick,
  input  wire                   bit_in,
  input  wire                   dump,
  input  wire [1:0]             grade,
  output reg  [`SDTS_RES_W-1:0] result_r
);
  reg  [`SDTS_RES_W-1:0] int1_r;
  reg  [`SDTS_RES_W-1:0] int2_r;
  reg  [`SDTS_RES_W-1:0] int3_r;
  reg  [`SDTS_RES_W-1:0] prev1_r;
  reg  [`SDTS_RES_W-1:0] prev2_r;
  reg  [`SDTS_RES_W-1:0] prev3_r;
  reg  [`SDTS_RES_W-1:0] sel;
  reg  [`SDTS_RES_W-1:0] d1;
  reg  [`SDTS_RES_W-1:0] d2;
  reg  [`SDTS_RES_W-1:0] d3;
  wire [`SDTS_RES_W-1:0] sample = bit_in ? `SDTS_PLUS1 : `SDTS_MINUS1;

  // integrators wrap modulo width; overflowing rates are software's to avoid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int1_r <= `SDTS_ZERO24;
      int2_r <= `SDTS_ZERO24;
      int3_r <= `SDTS_ZERO24;
    end else if (tick) begin
      int1_r <= int1_r + sample;
      int2_r <= int2_r + int1_r + sample;
      int3_r <= int3_r + int2_r + int1_r + sample;
    end
  end

  always @* begin
    sel = int1_r;
    d1  = `SDTS_ZERO24;
    d2  = `SDTS_ZERO24;
    d3  = `SDTS_ZERO24;
    case (grade)
      `SDTS_GRADE_CIC2: sel = int2_r;
      `SDTS_GRADE_CIC3: sel = int3_r;
      `SDTS_GRADE_FAST: sel = int1_r;
      default:          sel = int1_r;
    endcase
    d1 = sel - prev1_r;
    d2 = d1 - prev2_r;
    d3 = d2 - prev3_r;
  end

  // fast grade trades rejection for a single comb
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev1_r  <= `SDTS_ZERO24;
      prev2_r  <= `SDTS_ZERO24;
      prev3_r  <= `SDTS_ZERO24;
      result_r <= `SDTS_ZERO24;
    end else if (dump) begin
      prev1_r <= sel;
      prev2_r <= d1;
      prev3_r <= d2;
      case (grade)
        `SDTS_GRADE_CIC2: result_r <= d2;
        `SDTS_GRADE_CIC3: result_r <= d3;
        default:          result_r <= d1;
      endcase
    end
  end
endmodule // sdts_cic
`default_nettype wire

// ### rtl/sdts_top.v
// decimation channel with timestamp counters and apb register access
// assumes modulator clock and data pins asynchronous to pclk
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sdts_map.vh"
module sdts_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        mod_clk,
  input  wire        mod_data,
  output reg         result_ready_r
);
  reg  [2:0]             mclk_sync_r;
  reg  [2:0]             mdat_sync_r;
  reg                    mclk_lvl_r;
  reg                    mdat_lvl_r;
  reg                    tick_r;
  reg                    tick_bit_r;
  reg  [31:0]            cfg_r;
  reg  [`SDTS_CNT_W-1:0] down_cnt_r;
  reg  [`SDTS_CNT_W-1:0] down_cnt_nxt;
  reg  [`SDTS_CNT_W-1:0] res_cnt_r;
  reg  [`SDTS_CNT_W-1:0] res_cnt_nxt;
  reg                    dump_r;
  reg                    dump_nxt;
  reg                    out_r;
  reg                    out_nxt;
  reg                    overrun_r;
  reg  [`SDTS_ELA_W-1:0] elapsed_a_r;
  reg  [31:0]            rdata;
  reg                    rerr;
  wire [`SDTS_RES_W-1:0] result;
  wire [1:0]             grade  = cfg_r[`SDTS_CFG_GRADE];
  wire [`SDTS_CNT_W-1:0] factor = cfg_r[`SDTS_CFG_FACTOR];
  wire [`SDTS_CNT_W-1:0] outlen = cfg_r[`SDTS_CFG_OUTLEN];
  wire                   run    = cfg_r[`SDTS_CFG_EN] && (grade != `SDTS_GRADE_OFF);
  wire                   setup  = psel && !penable;
  wire                   done   = psel && penable && pready;
  wire                   wr     = done && pwrite;
  wire                   rd_res = done && !pwrite && (paddr == `SDTS_OFF_RESULT);

  // widened so a factor of FF cannot wrap the rate
  function [`SDTS_ELA_W-1:0] elapsed_a_of;
    input [`SDTS_CNT_W-1:0] cnt;
    input [`SDTS_CNT_W-1:0] df;
    input [`SDTS_CNT_W-1:0] dc;
    begin
      elapsed_a_of = {9'h000, cnt} * ({9'h000, df} + `SDTS_ONE17) + {9'h000, df - dc};
    end
  endfunction

  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // shared decodes; an edge counts only once two sync stages agree
  wire                   wr_cfg     = wr && hit(paddr, `SDTS_OFF_CFG);
  wire                   wr_stat    = wr && hit(paddr, `SDTS_OFF_STATUS);
  wire                   clr_ovr    = wr_stat && pwdata[`SDTS_STAT_OVR];
  wire                   mclk_agree = (mclk_sync_r[1] == mclk_sync_r[2]);
  wire                   mdat_agree = (mdat_sync_r[1] == mdat_sync_r[2]);
  wire                   mclk_rise  = run && !mclk_lvl_r && mclk_agree && mclk_sync_r[2];

  // pin sampling: first stage feeds only the second
  // mod_clk phases shorter than two pclk are lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_sync_r <= 3'h0;
      mdat_sync_r <= 3'h0;
      mclk_lvl_r  <= 1'b0;
      mdat_lvl_r  <= 1'b0;
      tick_r      <= 1'b0;
      tick_bit_r  <= 1'b0;
    end else begin
      mclk_sync_r <= {mclk_sync_r[1:0], mod_clk};
      mdat_sync_r <= {mdat_sync_r[1:0], mod_data};
      if (mclk_agree) begin
        mclk_lvl_r <= mclk_sync_r[2];
      end
      if (mdat_agree) begin
        mdat_lvl_r <= mdat_sync_r[2];
      end
      tick_r     <= mclk_rise;
      tick_bit_r <= mdat_lvl_r;
    end
  end

  // disabled or grade off: counters parked at factor and zero
  always @* begin
    down_cnt_nxt = down_cnt_r;
    res_cnt_nxt  = res_cnt_r;
    dump_nxt     = 1'b0;
    out_nxt      = 1'b0;
    if (!run) begin
      down_cnt_nxt = factor;
      res_cnt_nxt  = `SDTS_ZERO8;
    end else if (tick_r) begin
      if (down_cnt_r == `SDTS_ZERO8) begin
        down_cnt_nxt = factor;
        dump_nxt     = 1'b1;
        // count and reload share one edge, so no short elapsed value is seen
        if (res_cnt_r == outlen) begin
          res_cnt_nxt = `SDTS_ZERO8;
          out_nxt     = 1'b1;
        end else begin
          res_cnt_nxt = res_cnt_r + `SDTS_ONE8;
        end
      end else begin
        down_cnt_nxt = down_cnt_r - `SDTS_ONE8;
      end
    end
  end

  // elapsed follows the next-state counters so all three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      down_cnt_r  <= `SDTS_ZERO8;
      res_cnt_r   <= `SDTS_ZERO8;
      dump_r      <= 1'b0;
      out_r       <= 1'b0;
      elapsed_a_r <= {`SDTS_ELA_W{1'b0}};
    end else begin
      down_cnt_r  <= down_cnt_nxt;
      res_cnt_r   <= res_cnt_nxt;
      dump_r      <= dump_nxt;
      out_r       <= out_nxt;
      elapsed_a_r <= elapsed_a_of(res_cnt_nxt, factor, down_cnt_nxt);
    end
  end

  // one comb chain per channel; grade picks its depth
  sdts_cic sdts_cic_inst (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick_r),
    .bit_in   (tick_bit_r),
    .dump     (dump_r),
    .grade    (grade),
    .result_r (result)
  );

  // new result wins over a read clearing the flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ready_r <= 1'b0;
    end else if (out_r) begin
      result_ready_r <= 1'b1;
    end else if (rd_res) begin
      result_ready_r <= 1'b0;
    end
  end

  // a result lost to a slow reader wins over the software clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_r <= 1'b0;
    end else if (out_r && result_ready_r && !rd_res) begin
      overrun_r <= 1'b1;
    end else if (clr_ovr) begin
      overrun_r <= 1'b0;
    end
  end

  // read decode; unmapped offsets answer zero with an error
  always @* begin
    rdata = 32'h0000_0000;
    rerr  = 1'b0;
    case (paddr)
      `SDTS_OFF_CFG:     rdata = cfg_r;
      `SDTS_OFF_TSTAMP:  rdata = {16'h0000, res_cnt_r, down_cnt_r};
      `SDTS_OFF_RESULT:  rdata = {8'h00, result};
      `SDTS_OFF_STATUS: begin
        rdata[`SDTS_STAT_RDY] = result_ready_r;
        rdata[`SDTS_STAT_OVR] = overrun_r;
      end
      `SDTS_OFF_ELAPSED: rdata = {15'h0000, elapsed_a_r};
      default:           rerr  = 1'b1;
    endcase
  end

  // zero wait states: the answer stands only in the cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && rerr;
    end
  end

  // data captured at setup; a tick during the access shows on the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata;
    end
  end

  // reserved config bits are kept and read back as written
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `SDTS_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_r <= pwdata;
    end
  end
endmodule // sdts_top
`default_nettype wire

// ### testbench/sdts_top_properties.sv
// sdts_props: apb answer checks on the channel top ports
// assumes it is bound into sdts_top by the bind below
`timescale 1ns/1ps
`default_nettype none
module sdts_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        result_ready_r
);
  logic setup_w;
  assign setup_w = psel && !penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; setup_w |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_wait; setup_w |-> !pready; endproperty
  a_wait: assert property (p_wait) else $error("ready in setup");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("ready too long");
  property p_sel; pready |-> psel && penable; endproperty
  a_sel: assert property (p_sel) else $error("ready without access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unmap; setup_w && paddr > 8'h10 |=> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_map; setup_w && paddr == 8'h04 |=> !pslverr; endproperty
  a_map: assert property (p_map) else $error("timestamp refused");
  property p_zero; pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_zero: assert property (p_zero) else $error("refused read not zero");
  c_unmap: cover property (setup_w && paddr > 8'h10 ##1 pslverr);
  c_ready: cover property ($rose(result_ready_r));
  c_stamp: cover property (setup_w && paddr == 8'h04 && !pwrite);
endmodule // sdts_props
bind sdts_top sdts_props sdts_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .result_ready_r(result_ready_r));
`default_nettype wire

// ### testbench/sdts_mod_src.sv
// sdts_mod_src: modulator bit source for the channel
// assumes pclk from the bench; clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module sdts_mod_src (
  input  wire logic pclk,
  output var  logic mod_clk,
  output var  logic mod_data
);
  initial begin
    mod_clk = 1'b0;
    mod_data = 1'b0;
  end
  // four pclk per phase, above the two the synchroniser needs
  task automatic send(input int n);
    repeat (n) begin
      @(posedge pclk);
      mod_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      mod_clk <= 1'b0;
      mod_data <= ~mod_data;
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule // sdts_mod_src
`default_nettype wire

// ### testbench/test_sigma_delta_decimation_timestamp.sv
// test_sigma_delta_decimation_timestamp: self-checking bench
// assumes sdts_top, sdts_mod_src and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "sdts_map.vh"
module test_sigma_delta_decimation_timestamp;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        mod_clk, mod_data, result_ready_r, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          num_errors = 0;
  int          tests_run = 0;
  sdts_top sdts_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_clk(mod_clk), .mod_data(mod_data),
    .result_ready_r(result_ready_r));
  sdts_mod_src sdts_mod_src_inst (.pclk(pclk), .mod_clk(mod_clk), .mod_data(mod_data));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) begin
      num_errors++;
      $display("mismatch at %0t: no pready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // elapsed_a, then time for synchroniser and counter update
  task automatic elapsed_a(input int n);
    sdts_mod_src_inst.send(n);
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_reset;
    apb(1'b0, `SDTS_OFF_CFG, 32'h0);
    check(rd, `SDTS_CFG_RESET);
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, `SDTS_OFF_TSTAMP, 32'hFFFF);
    apb(1'b0, `SDTS_OFF_TSTAMP, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_counts;
    // rate 16 avoids every overflow pairing
    for (int g = 1; g < 4; g++) begin
      apb(1'b1, `SDTS_OFF_CFG, 32'h00FF0F00 | g);
      apb(1'b0, `SDTS_OFF_CFG, 32'h0);
      check(rd, 32'h00FF0F00 | g);
    end
    apb(1'b1, `SDTS_OFF_CFG, 32'h00FF0F06);
    elapsed_a(47);
    apb(1'b0, `SDTS_OFF_TSTAMP, 32'h0);
    check(rd, 32'h0000_0200);
    elapsed_a(1);
    apb(1'b0, `SDTS_OFF_TSTAMP, 32'h0);
    check(rd, 32'h0000_030F);
    apb(1'b0, `SDTS_OFF_ELAPSED, 32'h0);
    check(rd, 32'd48);
    elapsed_a(1);
    apb(1'b0, `SDTS_OFF_ELAPSED, 32'h0);
    check(rd, 32'd49);
    $display("test counts done");
  endtask
  task automatic t_output;
    apb(1'b1, `SDTS_OFF_CFG, 32'h0001_0302);
    elapsed_a(3);
    apb(1'b0, `SDTS_OFF_TSTAMP, 32'h0);
    check(rd, 32'h0000_0003);
    apb(1'b1, `SDTS_OFF_CFG, 32'h0001_0306);
    elapsed_a(7);
    apb(1'b0, `SDTS_OFF_TSTAMP, 32'h0);
    check(rd, 32'h0000_0100);
    check({31'h0, result_ready_r}, 32'h0);
    elapsed_a(1);
    check({31'h0, result_ready_r}, 32'h1);
    apb(1'b0, `SDTS_OFF_ELAPSED, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `SDTS_OFF_RESULT, 32'h0);
    @(posedge pclk);
    check({31'h0, result_ready_r}, 32'h0);
    $display("test output done");
  endtask
  // rate 3, one output per value; data alternates per tick, 60 elapsed_a sent so far
  task automatic t_grades;
    apb(1'b1, `SDTS_OFF_CFG, 32'h0000_0203);
    apb(1'b1, `SDTS_OFF_CFG, 32'h0000_0207);
    elapsed_a(6);
    apb(1'b0, `SDTS_OFF_STATUS, 32'h0);
    check(rd, 32'h0000_0003);
    apb(1'b0, `SDTS_OFF_RESULT, 32'h0);
    check(rd, 32'h0000_0001);
    apb(1'b0, `SDTS_OFF_TSTAMP, 32'h0);
    check(rd, 32'h0000_0002);
    apb(1'b1, `SDTS_OFF_STATUS, 32'h0000_0002);
    apb(1'b0, `SDTS_OFF_STATUS, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b1, `SDTS_OFF_CFG, 32'h0000_0205);
    elapsed_a(9);
    apb(1'b0, `SDTS_OFF_RESULT, 32'h0);
    check(rd, 32'h00FF_FFFF);
    $display("test grades done");
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_counts();
    t_output();
    t_grades();
    summarize();
  end
endmodule // test_sigma_delta_decimation_timestamp
`default_nettype wire
